// File: clfm_pkg.sv
// shared constants and types for the contactor life and fault monitor
package clfm_pkg;
	// time base
	localparam int CLK_HZ = 200000000;
	localparam int US_PER_S = 1000000;
	localparam int TICK_CYCLES = CLK_HZ / US_PER_S;
	// usual configuration values
	localparam logic [7:0] SPREAD_LIMIT_DEF = 8'h0f;
	localparam logic [31:0] WINDOW_US_DEF = 32'h001e8480;
	localparam logic [31:0] MEMCHK_US_DEF = 32'h03938700;
	localparam logic [7:0] FAULT_PCT_DEF = 8'h00;
	localparam logic [6:0] PCT_FULL = 7'h64;
	// capture states, gray in declared order
	typedef enum logic [1:0] {
		CAP_IDLE = 2'b00,
		CAP_PRE = 2'b01,
		CAP_POST = 2'b11,
		CAP_EVAL = 2'b10
	} clfm_cap_t;
	// per-contactor configuration
	typedef struct packed {
		logic monitor_en;
		logic tracker_en;
		logic precharge_role_flag;
		logic [31:0] window_us;
		logic [15:0] min_current;
		logic [15:0] max_current;
		logic [15:0] rated_current;
		logic [31:0] max_life;
	} clfm_cfg_t;
	// per-contactor status
	typedef struct packed {
		logic end_of_life;
		logic wear_warning;
		logic wear_fault;
		logic precharge_role_flag;
		logic [31:0] life_count;
		logic [6:0] remaining_pct;
	} clfm_stat_t;
endpackage

// File: clfm_monitor.sv
// contactor life tracking, temperature spread, watchdogs and freshness
`timescale 1ns/100ps
// Operation
// - per module, compute hottest minus coldest thermistor reading
// - trip spread fault when spread exceeds configurable limit, usually 15
// - contactor n has its own monitor and tracker configuration
// - opening events observed only while monitor enable is 1
// - life accumulates only while tracker enable is 1
// - precharge flag marks tracked contactor as the precharge one
// - opening current is peak sample in window centred on opening
// - life count increments only above minimum opening current
// - current above maximum marks end of life at once
// - unmonitored opening uses maximum rated current
// - end of life once count exceeds maximum life
// - warning when remaining percent falls below warning level
// - fault when remaining percent falls below fault level, usually 0
// - watchdog expires unless reset in period, tripping and opening
// - watchdog expired flag 1 after period unreset, else 0
// - separate RAM-check and ROM-check watchdogs, usually 60 s
// - freshness stale flag 1 when data not refreshed in period
// - each freshness monitor has a configurable refresh period
module clfm_monitor
	import clfm_pkg::*;
#(
	parameter int N_CONT = 2,
	parameter int N_MOD = 4,
	parameter int N_THERM = 4,
	parameter int N_FRESH = 4,
	parameter int TEMP_W = 8
) (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	// temperature inputs, signed degrees C
	input wire logic [N_MOD*N_THERM*TEMP_W-1:0] therm_temp,
	input wire logic [7:0] module_temp_spread_limit,
	output logic [N_MOD-1:0] spread_fault,
	// current samples and contactor events
	input wire logic [15:0] current_sample,
	input wire logic current_valid,
	input wire logic [N_CONT-1:0] open_event,
	input wire logic [N_CONT-1:0] open_unmonitored,
	input wire clfm_cfg_t [N_CONT-1:0] cont_cfg,
	input wire logic [7:0] wear_warning_level,
	input wire logic [7:0] wear_fault_level,
	output clfm_stat_t [N_CONT-1:0] cont_stat,
	// watchdogs
	input wire logic [31:0] ram_check_period_us,
	input wire logic [31:0] rom_check_period_us,
	input wire logic ram_check_kick,
	input wire logic rom_check_kick,
	output logic ram_check_timer,
	output logic rom_check_timer,
	output logic open_contactors_req,
	// freshness
	input wire logic [N_FRESH*32-1:0] fresh_period_us,
	input wire logic [N_FRESH-1:0] fresh_update,
	output logic [N_FRESH-1:0] fresh_stale
);
	initial begin
		if (N_CONT < 1 || N_MOD < 1 || N_THERM < 2 || N_FRESH < 1)
			$error("clfm_monitor: unsupported size parameters");
		if (TEMP_W < 2 || TEMP_W > 16)
			$error("clfm_monitor: temperature width out of range");
	end

	// ----------------------------------------------------------------
	// microsecond tick
	// ----------------------------------------------------------------
	logic [7:0] div_reg, div_next;
	logic tick;
	always_comb begin
		tick = (div_reg == 8'(TICK_CYCLES - 1));
		div_next = tick ? 8'h00 : div_reg + 8'h01;
	end
	always_ff @(posedge clk) begin
		if (sys_rst)
			div_reg <= 8'h00;
		else if (clk_en)
			div_reg <= div_next;
	end

	// ----------------------------------------------------------------
	// temperature spread
	// ----------------------------------------------------------------
	logic [N_MOD-1:0] spread_next, spread_reg;
	for (genvar m = 0; m < N_MOD; m++) begin : g_mod
		logic signed [TEMP_W-1:0] t_max, t_min, t_v;
		logic signed [TEMP_W:0] spread;
		always_comb begin
			t_max = TEMP_W'(therm_temp[m*N_THERM*TEMP_W +: TEMP_W]);
			t_min = t_max;
			t_v = t_max;
			for (int k = 1; k < N_THERM; k++) begin
				t_v = therm_temp[(m*N_THERM+k)*TEMP_W +: TEMP_W];
				if (t_v > t_max)
					t_max = t_v;
				if (t_v < t_min)
					t_min = t_v;
			end
			spread = (TEMP_W+1)'(t_max) - (TEMP_W+1)'(t_min);
			spread_next[m] = ($unsigned(spread) > (TEMP_W+1)'(
				module_temp_spread_limit));
		end
	end
	always_ff @(posedge clk) begin
		if (sys_rst)
			spread_reg <= '0;
		else if (clk_en)
			spread_reg <= spread_next;
	end
	assign spread_fault = spread_reg;

	// ----------------------------------------------------------------
	// contactor life tracking
	// ----------------------------------------------------------------
	// one tracker per contactor index
	for (genvar c = 0; c < N_CONT; c++) begin : g_cont
		clfm_cap_t st_reg, st_next;
		logic [31:0] tmr_reg, tmr_next;
		logic [15:0] peak_reg, peak_next;
		logic [31:0] life_reg, life_next;
		logic eol_reg, eol_next;
		logic pre_reg, pre_next;
		logic [6:0] pct;
		logic [31:0] half;
		logic [38:0] prod;
		logic [31:0] left;
		always_comb begin
			half = {1'b0, cont_cfg[c].window_us[31:1]};
			st_next = st_reg;
			tmr_next = tmr_reg;
			peak_next = peak_reg;
			life_next = life_reg;
			eol_next = eol_reg;
			pre_next = cont_cfg[c].precharge_role_flag;
			if (tick && st_reg != CAP_IDLE)
				tmr_next = tmr_reg + 32'h1;
			if (current_valid && st_reg != CAP_EVAL &&
				current_sample > peak_reg)
				peak_next = current_sample;
			case (st_reg)
			CAP_IDLE: begin
				// pre-window samples: peak clears to zero every half window plus one microsecond tick
				if (tick && tmr_reg >= half) begin
					peak_next = 16'h0;
					tmr_next = 32'h0;
				end else if (tick)
					tmr_next = tmr_reg + 32'h1;
				if (cont_cfg[c].monitor_en && open_event[c]) begin
					st_next = CAP_POST;
					tmr_next = 32'h0;
				end else if (open_unmonitored[c] &&
					cont_cfg[c].tracker_en) begin
					peak_next = cont_cfg[c].rated_current;
					st_next = CAP_EVAL;
				end
			end
			CAP_PRE:
				st_next = CAP_POST;
			CAP_POST: begin
				if (tmr_reg >= half)
					st_next = CAP_EVAL;
			end
			CAP_EVAL: begin
				if (cont_cfg[c].tracker_en) begin
					if (peak_reg > cont_cfg[c].min_current &&
						life_reg != 32'hffffffff)
						life_next = life_reg + 32'h1;
					if (peak_reg > cont_cfg[c].max_current)
						eol_next = 1'b1;
				end
				st_next = CAP_IDLE;
				tmr_next = 32'h0;
				peak_next = 16'h0;
			end
			default:
				st_next = CAP_IDLE;
			endcase
			if (life_reg > cont_cfg[c].max_life)
				eol_next = 1'b1;
			left = (life_reg >= cont_cfg[c].max_life) ? 32'h0 :
				cont_cfg[c].max_life - life_reg;
			prod = 39'(left) * 39'(PCT_FULL);
			pct = (cont_cfg[c].max_life == 32'h0) ? 7'h0 :
				7'(prod / 39'(cont_cfg[c].max_life));
		end
		always_ff @(posedge clk) begin
			if (sys_rst) begin
				st_reg <= CAP_IDLE;
				tmr_reg <= 32'h0;
				peak_reg <= 16'h0;
				life_reg <= 32'h0;
				eol_reg <= 1'b0;
				pre_reg <= 1'b0;
			end else if (clk_en) begin
				st_reg <= st_next;
				tmr_reg <= tmr_next;
				peak_reg <= peak_next;
				life_reg <= life_next;
				eol_reg <= eol_next;
				pre_reg <= pre_next;
			end
		end
		// precharge role travels with the tracker config
		always_comb begin
			cont_stat[c].end_of_life = eol_reg;
			cont_stat[c].precharge_role_flag = pre_reg;
			cont_stat[c].life_count = life_reg;
			cont_stat[c].remaining_pct = pct;
			cont_stat[c].wear_warning = cont_cfg[c].tracker_en &&
				({1'b0, pct} < wear_warning_level);
			cont_stat[c].wear_fault = cont_cfg[c].tracker_en &&
				(({1'b0, pct} < wear_fault_level) || eol_reg);
		end
		// no increment at or below minimum current
		AST_NO_LOW_COUNT: assert property (@(posedge clk)
			disable iff (sys_rst)
			(clk_en && st_reg == CAP_EVAL &&
			peak_reg <= cont_cfg[c].min_current)
			|=> $stable(life_reg))
			else $error("life counted at low current");
		// high current sets end of life next cycle
		AST_HIGH_EOL: assert property (@(posedge clk)
			disable iff (sys_rst)
			(clk_en && st_reg == CAP_EVAL && cont_cfg[c].tracker_en &&
			peak_reg > cont_cfg[c].max_current) |=> eol_reg)
			else $error("high current did not mark end of life");
		AST_TRK_OFF: assert property (@(posedge clk)
			disable iff (sys_rst)
			!cont_cfg[c].tracker_en |=> $stable(life_reg))
			else $error("life counted while tracker disabled");
		AST_MON_OFF: assert property (@(posedge clk)
			disable iff (sys_rst)
			(clk_en && st_reg == CAP_IDLE && !cont_cfg[c].monitor_en &&
			!open_unmonitored[c]) |=> st_reg == CAP_IDLE)
			else $error("event observed while monitor disabled");
		// capture closes after one evaluation cycle
		sequence s_eval;
			clk_en && st_reg == CAP_EVAL;
		endsequence
		AST_EVAL_ONE: assert property (@(posedge clk)
			disable iff (sys_rst) s_eval |=> st_reg == CAP_IDLE)
			else $error("capture did not return to idle");
	end

	// ----------------------------------------------------------------
	// watchdogs and freshness timers
	// ----------------------------------------------------------------
	localparam int N_TMR = N_FRESH + 2;
	logic [N_TMR-1:0] kick, expd;
	logic [N_TMR*32-1:0] per;
	always_comb begin
		// RAM and ROM checks are separate timers
		kick = {fresh_update, rom_check_kick, ram_check_kick};
		per = {fresh_period_us, rom_check_period_us, ram_check_period_us};
	end
	for (genvar t = 0; t < N_TMR; t++) begin : g_tmr
		logic [31:0] cnt_reg, cnt_next;
		logic exp_reg, exp_next;
		always_comb begin
			cnt_next = cnt_reg;
			exp_next = exp_reg;
			if (kick[t]) begin
				cnt_next = 32'h0;
				exp_next = 1'b0;
			end else if (tick && !exp_reg) begin
				if (cnt_reg + 32'h1 >= per[t*32 +: 32])
					exp_next = 1'b1;
				else
					cnt_next = cnt_reg + 32'h1;
			end
		end
		always_ff @(posedge clk) begin
			if (sys_rst) begin
				cnt_reg <= 32'h0;
				exp_reg <= 1'b0;
			end else if (clk_en) begin
				cnt_reg <= cnt_next;
				exp_reg <= exp_next;
			end
		end
		assign expd[t] = exp_reg;
		// a kick clears the expired flag
		AST_KICK_CLR: assert property (@(posedge clk)
			disable iff (sys_rst)
			(clk_en && kick[t]) |=> !exp_reg)
			else $error("timer expired right after a reset");
		AST_KICK_ZERO: assert property (@(posedge clk)
			disable iff (sys_rst)
			(clk_en && kick[t]) |=> cnt_reg == 32'h0)
			else $error("timer did not restart at zero");
	end

	// watchdog expiry trips and opens contactors
	always_comb begin
		ram_check_timer = expd[0];
		rom_check_timer = expd[1];
		open_contactors_req = expd[0] | expd[1];
		fresh_stale = expd[N_TMR-1:2];
	end

	AST_WDT_OPEN: assert property (@(posedge clk)
		disable iff (sys_rst)
		(ram_check_timer || rom_check_timer) |-> open_contactors_req)
		else $error("watchdog expiry did not open contactors");
	AST_SPREAD: assert property (@(posedge clk) disable iff (sys_rst)
		clk_en |=> spread_fault == $past(spread_next))
		else $error("spread fault mismatch");
endmodule

// File: clfm_src.sv
// current shunt model feeding periodic samples
`timescale 1ns/100ps
module clfm_src (
	// clock
	input wire logic clk,
	// current level to report
	input wire logic [15:0] level,
	// sample stream
	output logic [15:0] current_sample,
	output logic current_valid
);
	logic [5:0] cnt_reg = 6'h00;
	initial current_sample = 16'h5a5a;
	initial current_valid = 1'b0;
	// one sample every 50 clocks, data toggles between samples
	always_ff @(posedge clk) begin
		cnt_reg <= (cnt_reg == 6'h31) ? 6'h00 : cnt_reg + 6'h01;
		current_valid <= (cnt_reg == 6'h31);
		current_sample <= (cnt_reg == 6'h31) ? level : ~current_sample;
	end
endmodule

// File: contactor_life_fault_monitor_tb.sv
// testbench for the contactor life and fault monitor
`timescale 1ns/100ps
module contactor_life_fault_monitor_tb;
	import clfm_pkg::*;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [127:0] therm = {16{8'h14}};
	logic [15:0] level = 16'h0000;
	logic [15:0] cs;
	logic cv;
	logic [1:0] ev = 2'b00;
	logic [1:0] unmon = 2'b00;
	clfm_cfg_t [1:0] cfg;
	clfm_stat_t [1:0] stat;
	logic [3:0] spread;
	logic [7:0] lim = 8'h0f;
	logic ce = 1'b1;
	logic kr = 1'b0;
	logic kq = 1'b0;
	logic rt, qt, ocr;
	logic [3:0] upd = 4'h0;
	logic [3:0] stale;
	int err_count = 0;
	int checked = 0;
	initial begin
		cfg[0] = '{1'b1, 1'b1, 1'b0, 32'h4, 16'h64, 16'hc8, 16'h96, 32'h4};
		cfg[1] = '{1'b0, 1'b1, 1'b1, 32'h4, 16'h64, 16'hc8, 16'h96, 32'h1};
	end
	initial forever #2.5 clk = ~clk;
	clfm_src src (.clk(clk), .level(level), .current_sample(cs),
		.current_valid(cv));
	clfm_monitor dut (.clk(clk), .sys_rst(sys_rst), .clk_en(ce),
		.therm_temp(therm), .module_temp_spread_limit(lim),
		.spread_fault(spread), .current_sample(cs), .current_valid(cv),
		.open_event(ev), .open_unmonitored(unmon), .cont_cfg(cfg),
		.wear_warning_level(8'h3c), .wear_fault_level(8'h00),
		.cont_stat(stat), .ram_check_period_us(32'h8),
		.rom_check_period_us(32'h4), .ram_check_kick(kr),
		.rom_check_kick(kq), .ram_check_timer(rt), .rom_check_timer(qt),
		.open_contactors_req(ocr),
		.fresh_period_us({32'h8, 32'h4, 32'h8, 32'h4}),
		.fresh_update(upd), .fresh_stale(stale));
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task us(input int n);
		repeat (n * 200) @(posedge clk);
	endtask
	task finish_test;
		if (err_count == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task open_with(input logic [15:0] cur);
		level <= cur;
		us(3);
		ev <= 2'b11;
		@(posedge clk);
		ev <= 2'b00;
		us(5);
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task t_spread;
		therm[7:0] <= 8'h0a;
		therm[15:8] <= 8'h19;
		us(1);
		chk(32'(spread), 32'h0);
		therm[15:8] <= 8'h1a;
		repeat (3) @(posedge clk);
		chk(32'(spread), 32'h1);
		lim <= 8'h10;
		therm[127:120] <= 8'hfb;
		repeat (3) @(posedge clk);
		chk(32'(spread), 32'h8);
		lim <= 8'h0f;
		therm[15:0] <= 16'h1414;
		therm[127:120] <= 8'h14;
	endtask
	task t_life;
		open_with(16'h96);
		chk(stat[0].life_count, 32'h1);
		chk(stat[1].life_count, 32'h0);
		chk(32'(stat[0].precharge_role_flag), 32'h0);
		chk(32'(stat[1].precharge_role_flag), 32'h1);
		open_with(16'h64);
		chk(stat[0].life_count, 32'h1);
		cfg[0].tracker_en <= 1'b0;
		open_with(16'h96);
		chk(stat[0].life_count, 32'h1);
		cfg[0].tracker_en <= 1'b1;
		@(posedge clk);
		unmon <= 2'b01;
		@(posedge clk);
		unmon <= 2'b00;
		us(1);
		chk(stat[0].life_count, 32'h2);
		chk(32'(stat[0].remaining_pct), 32'h32);
		chk(32'(stat[0].wear_warning), 32'h1);
		chk(32'(stat[0].wear_fault), 32'h0);
		chk(32'(stat[0].end_of_life), 32'h0);
		open_with(16'hc9);
		chk(32'(stat[0].end_of_life), 32'h1);
		chk(32'(stat[0].wear_fault), 32'h1);
		cfg[1].monitor_en <= 1'b1;
		open_with(16'h96);
		chk(32'(stat[1].end_of_life), 32'h0);
		open_with(16'h96);
		chk(32'(stat[1].end_of_life), 32'h1);
		chk(32'(stat[1].remaining_pct), 32'h0);
	endtask
	task t_wdog;
		kr <= 1'b1;
		kq <= 1'b1;
		upd <= 4'hf;
		@(posedge clk);
		kr <= 1'b0;
		kq <= 1'b0;
		upd <= 4'h0;
		us(2);
		chk(32'({rt, qt, ocr, stale}), 32'h0);
		us(4);
		chk(32'(rt), 32'h0);
		chk(32'(qt), 32'h1);
		chk(32'(ocr), 32'h1);
		chk(32'(stale), 32'h5);
		kq <= 1'b1;
		upd <= 4'hf;
		@(posedge clk);
		kq <= 1'b0;
		upd <= 4'h0;
		repeat (2) @(posedge clk);
		chk(32'({rt, qt, ocr, stale}), 32'h0);
	endtask
	task t_freeze;
		ce <= 1'b0;
		us(10);
		chk(32'(rt), 32'h0);
		ce <= 1'b1;
		us(3);
		chk(32'(rt), 32'h1);
		chk(32'(ocr), 32'h1);
	endtask
	task t_reset;
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		chk(stat[0].life_count, 32'h0);
		chk(32'(stat[1].end_of_life), 32'h0);
		chk(32'({rt, ocr, stat[0].end_of_life}), 32'h0);
	endtask
	// ----------------------------------------
	// sequence and watchdog
	// ----------------------------------------
	initial begin
		repeat (6) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		t_spread;
		t_life;
		t_wdog;
		t_freeze;
		t_reset;
		finish_test;
	end
	initial begin
		repeat (40000) @(posedge clk);
		err_count++;
		finish_test;
	end
endmodule
